// ===== rtl/wdt_pkg.sv
package wdt_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 4;

  // window timing, shortest setting gives the shortest timeout
  localparam int MIN_TIMEOUT_NS = 270000;
  localparam int MIN_UPPER_CYC = MIN_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int LONG_RATIO = 30;
  localparam int SHORT_RATIO = 10;
  localparam int RATIO_KNEE = 4;
  localparam int BLANK_DIV = 64;

  // release delay: four up-and-down ramp cycles
  localparam int MIN_RELEASE_NS = 40000;
  localparam int RELEASE_CYCLES = 4;
  localparam int MIN_RAMP_CYC =
    MIN_RELEASE_NS / RELEASE_CYCLES / CLK_PERIOD_NS;

  // enable latency, least time rounds up
  localparam int ENABLE_LATENCY_NS = 1000;
  localparam int ENABLE_LATENCY_CYC =
    (ENABLE_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // sense glitch filter, least time rounds up
  localparam int UV_GLITCH_NS = 23000;
  localparam int UV_GLITCH_CYC =
    (UV_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // synchroniser bit positions
  localparam int SYNC_W = 6;
  localparam int IDX_KICK = 0;
  localparam int IDX_EN = 1;
  localparam int IDX_UV = 2;
  localparam int IDX_SLOW = 3;
  localparam int IDX_HOT = 4;
  localparam int IDX_SUPOK = 5;
  // idle levels: supply ok, sense ok, kick high; no reset-pin blip
  localparam logic [SYNC_W-1:0] SYNC_RST = 6'h25;

  typedef enum logic [2:0] {
    WD_HOLD,
    WD_OFF,
    WD_LATENCY,
    WD_BLANK,
    WD_WATCH,
    WD_FAULT
  } wd_state_t;

endpackage : wdt_pkg

// ===== rtl/delay_if.sv
`timescale 1ns/1ns
interface delay_if #(parameter int CNT_W = 24);
  logic clear;
  logic reset_cond;
  logic fault_start;
  logic [CNT_W-1:0] cycle_len;
  logic fault_busy;
  logic reset_busy;
  logic fault_done;

  modport timer (
    input clear,
    input reset_cond,
    input fault_start,
    input cycle_len,
    output fault_busy,
    output reset_busy,
    output fault_done
  );

  modport ctrl (
    output clear,
    output reset_cond,
    output fault_start,
    output cycle_len,
    input fault_busy,
    input reset_busy,
    input fault_done
  );
endinterface : delay_if

// ===== rtl/release_timer.sv
`timescale 1ns/1ns
module release_timer #(
  parameter int CNT_W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control side
  delay_if.timer d
);

  localparam logic [2:0] LAST = 3'(wdt_pkg::RELEASE_CYCLES - 1);

  logic [CNT_W-1:0] ramp_r;
  logic [CNT_W-1:0] ramp_nxt;
  logic [2:0] fcnt_r;
  logic [2:0] rcnt_r;
  logic fbusy_r;
  logic rbusy_r;

  // one ramp serves both outputs
  wire run = fbusy_r | (rbusy_r & ~d.reset_cond); // R16
  wire tick = run & (ramp_r == d.cycle_len - CNT_W'(1));
  wire fdone = fbusy_r & tick & (fcnt_r == LAST); // R8
  wire rdone = rbusy_r & ~d.reset_cond & tick & (rcnt_r == LAST); // R14

  // a fault restarts the ramp, so the reset loses its partial cycle
  assign ramp_nxt = (d.fault_start | ~run | tick) ? '0 :
                    ramp_r + CNT_W'(1); // R17

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_r <= '0;
      fcnt_r <= 3'h0;
      rcnt_r <= 3'h0;
      fbusy_r <= 1'b0;
      rbusy_r <= 1'b1;
    end else if (d.clear) begin
      ramp_r <= '0; // R9
      fcnt_r <= 3'h0;
      rcnt_r <= 3'h0;
      fbusy_r <= 1'b0;
      rbusy_r <= 1'b1;
    end else begin
      ramp_r <= ramp_nxt;
      if (d.fault_start) begin
        fbusy_r <= 1'b1; // R1
        fcnt_r <= 3'h0;
      end else if (fdone) begin
        fbusy_r <= 1'b0;
      end else if (tick && fbusy_r) begin
        fcnt_r <= fcnt_r + 3'h1;
      end
      if (d.reset_cond) begin
        rbusy_r <= 1'b1;
        rcnt_r <= 3'h0;
      end else if (rdone) begin
        rbusy_r <= 1'b0;
      end else if (tick && rbusy_r) begin
        rcnt_r <= rcnt_r + 3'h1;
      end
    end
  end

  assign d.fault_busy = fbusy_r;
  assign d.reset_busy = rbusy_r;
  assign d.fault_done = fdone;

endmodule : release_timer

// ===== rtl/window_watchdog_reset_supervisor.sv
`timescale 1ns/1ns
// How it works
// R1 - kick interval shorter than lower or longer than upper bound faults
// R2 - no kick within the whole upper bound also faults
// R3 - controller must kick strictly inside the window
// R4 - both bounds come from one setting; ratio 30, smaller when short
// R5 - smallest window setting gives about 270 us timeout
// R6 - supply-low or overheat stops watchdog; restart from zero with blanking
// R7 - enable low stops watchdog; after rise, latency then blanking
// R8 - kicks ignored during fault; release after four cycles, then blank
// R9 - supply-low asserts reset, stops regulator, clears all timing
// R10 - any reset condition drives reset low while a supply stays up
// R11 - overheat asserts reset, stops regulator, clears all timing
// R12 - sense input below threshold asserts reset
// R13 - sense-only reset leaves regulator and watchdog untouched
// R14 - reset held four delay cycles after all conditions clear
// R15 - smallest delay setting gives about 40 us release delay
// R16 - fault pulse timed by the same delay counter
// R17 - fault has priority on the counter; reset may stretch
// R18 - release delay never holds back regulator or watchdog
// R19 - reset output may be tied to the enable input
// R20 - sense must stay low about 23 us before reset asserts
// R21 - all ramps replaced by counts of the block clock
module window_watchdog_reset_supervisor #(
  parameter int SET_W = 4,
  parameter int CNT_W = 24,
  parameter int UPPER_MIN_CYC = wdt_pkg::MIN_UPPER_CYC,
  parameter int UV_CYC = wdt_pkg::UV_GLITCH_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // pins from the controller
  input wire logic KICK_INPUT,
  input wire logic SUPERVISOR_ENABLE,
  input wire logic UNDERVOLTAGE_SENSE_IN,
  // device status
  input wire logic SUPPLY_LOW,
  input wire logic OVERTEMP,
  input wire logic RESET_SUPPLY_OK,
  // static timing settings
  input wire logic [SET_W-1:0] WINDOW_SETTING,
  input wire logic [SET_W-1:0] DELAY_SETTING,
  // open-drain fault pin
  output logic WINDOW_FAULT_OUT_N_O,
  output logic WINDOW_FAULT_OUT_N_OE,
  // open-drain reset pin
  output logic RESET_OUT_N_O,
  output logic RESET_OUT_N_OE,
  // regulator control
  output logic REGULATOR_ENABLE,
  output logic SOFTSTART_CLEAR,
  // status
  output logic WATCHDOG_ACTIVE,
  output logic FAULT_EARLY,
  output logic FAULT_LATE
);

  localparam int LAT_CYC = wdt_pkg::ENABLE_LATENCY_CYC;
  localparam int LAT_W = $clog2(LAT_CYC + 1);
  localparam int UVC_W = $clog2(UV_CYC + 1);

  // synchronisers
  logic [wdt_pkg::SYNC_W-1:0] sync1_r;
  logic [wdt_pkg::SYNC_W-1:0] sync2_r;
  logic kick_prev_r;

  // sense filter
  logic [UVC_W-1:0] uv_cnt_r;
  logic uv_trip_r;

  // watchdog
  wdt_pkg::wd_state_t state_r;
  wdt_pkg::wd_state_t state_nxt;
  logic [LAT_W-1:0] lat_r;
  logic [CNT_W-1:0] wcnt_r;
  logic [CNT_W-1:0] wcnt_nxt;

  // output flops
  logic fault_oe_r;
  logic rst_oe_r;
  logic reg_en_r;
  logic ss_clr_r;
  logic wd_act_r;
  logic early_r;
  logic late_r;

  delay_if #(.CNT_W(CNT_W)) dly ();

  release_timer #(.CNT_W(CNT_W)) u_timer (
    .clk(CLK),
    .rst_n(RESETN),
    .d(dly.timer)
  );

  // every pin is asynchronous to CLK
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1_r <= wdt_pkg::SYNC_RST;
      sync2_r <= wdt_pkg::SYNC_RST;
    end else begin
      sync1_r <= {RESET_SUPPLY_OK, OVERTEMP, SUPPLY_LOW,
                  UNDERVOLTAGE_SENSE_IN, SUPERVISOR_ENABLE, KICK_INPUT};
      sync2_r <= sync1_r;
    end
  end

  wire kick_s = sync2_r[wdt_pkg::IDX_KICK];
  wire en_s = sync2_r[wdt_pkg::IDX_EN];
  wire uv_ok_s = sync2_r[wdt_pkg::IDX_UV];
  wire slow_s = sync2_r[wdt_pkg::IDX_SLOW];
  wire hot_s = sync2_r[wdt_pkg::IDX_HOT];
  wire supok_s = sync2_r[wdt_pkg::IDX_SUPOK];

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      kick_prev_r <= 1'b0;
    end else begin
      kick_prev_r <= kick_s;
    end
  end

  wire kick_fall = kick_prev_r & ~kick_s;

  // supply-low and overheat act alike
  wire lockout = slow_s | hot_s; // R9 R11

  // sense glitch filter: short dips never reach the reset pin
  wire uv_full = (uv_cnt_r == UVC_W'(UV_CYC - 1));

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      uv_cnt_r <= '0;
      uv_trip_r <= 1'b0;
    end else if (uv_ok_s) begin
      uv_cnt_r <= '0;
      uv_trip_r <= 1'b0;
    end else if (uv_full) begin
      uv_trip_r <= 1'b1; // R12 R20
    end else begin
      uv_cnt_r <= uv_cnt_r + UVC_W'(1);
    end
  end

  // sense trips only the reset path, not the watchdog
  wire reset_cond = lockout | uv_trip_r; // R13

  // window bounds from one setting
  wire [CNT_W-1:0] win_mult = CNT_W'(WINDOW_SETTING) + CNT_W'(1);
  wire [CNT_W-1:0] upper_cyc = CNT_W'(UPPER_MIN_CYC) * win_mult; // R5 R21
  wire long_set = (WINDOW_SETTING >= SET_W'(wdt_pkg::RATIO_KNEE));
  wire [CNT_W-1:0] lower_long = upper_cyc / CNT_W'(wdt_pkg::LONG_RATIO);
  wire [CNT_W-1:0] lower_short = upper_cyc / CNT_W'(wdt_pkg::SHORT_RATIO);
  wire [CNT_W-1:0] lower_cyc = long_set ? lower_long : lower_short; // R4
  // blanking kept well below the lower bound so a good kick is never lost
  wire [CNT_W-1:0] blank_cyc = upper_cyc / CNT_W'(wdt_pkg::BLANK_DIV); // R21

  // release delay ramp length
  wire [CNT_W-1:0] dly_mult = CNT_W'(DELAY_SETTING) + CNT_W'(1);
  wire [CNT_W-1:0] ramp_cyc =
    CNT_W'(wdt_pkg::MIN_RAMP_CYC) * dly_mult; // R15 R21

  // window checks
  wire in_watch = (state_r == wdt_pkg::WD_WATCH);
  wire in_blank = (state_r == wdt_pkg::WD_BLANK);
  wire too_late = in_watch & (wcnt_r >= upper_cyc); // R2
  wire too_early = in_watch & kick_fall & (wcnt_r < lower_cyc) &
                   ~too_late; // R1
  wire good_kick = in_watch & kick_fall & ~too_early & ~too_late;
  wire blank_done = in_blank & (wcnt_r >= blank_cyc);
  wire lat_done = (lat_r == LAT_W'(LAT_CYC - 1));
  wire enter_fault = (too_early | too_late) & ~lockout & en_s;
  wire wcnt_sat = (wcnt_r == {CNT_W{1'b1}});

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      wdt_pkg::WD_HOLD: begin
        // watchdog restarts at once, not after the reset delay
        state_nxt = en_s ? wdt_pkg::WD_BLANK : wdt_pkg::WD_OFF; // R18
      end
      wdt_pkg::WD_OFF: begin
        if (en_s) begin
          state_nxt = wdt_pkg::WD_LATENCY;
        end
      end
      wdt_pkg::WD_LATENCY: begin
        if (lat_done) begin
          state_nxt = wdt_pkg::WD_BLANK; // R7
        end
      end
      wdt_pkg::WD_BLANK: begin
        if (blank_done) begin
          state_nxt = wdt_pkg::WD_WATCH;
        end
      end
      wdt_pkg::WD_WATCH: begin
        if (too_early || too_late) begin
          state_nxt = wdt_pkg::WD_FAULT; // R1
        end
      end
      wdt_pkg::WD_FAULT: begin
        if (dly.fault_done) begin
          state_nxt = wdt_pkg::WD_BLANK; // R8
        end
      end
    endcase
    if (lockout) begin
      state_nxt = wdt_pkg::WD_HOLD; // R6
    end else if (!en_s) begin
      state_nxt = wdt_pkg::WD_OFF; // R7
    end
  end

  // window count runs in blanking and watching; kicks in blanking ignored
  always_comb begin
    wcnt_nxt = wcnt_r;
    if (state_nxt != wdt_pkg::WD_BLANK &&
        state_nxt != wdt_pkg::WD_WATCH) begin
      wcnt_nxt = '0; // R6 R8
    end else if (state_r != state_nxt && !in_blank) begin
      wcnt_nxt = '0;
    end else if (good_kick) begin
      wcnt_nxt = '0;
    end else if (!wcnt_sat) begin
      wcnt_nxt = wcnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= wdt_pkg::WD_HOLD;
      wcnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      wcnt_r <= wcnt_nxt;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      lat_r <= '0;
    end else if (state_r != wdt_pkg::WD_LATENCY) begin
      lat_r <= '0;
    end else if (!lat_done) begin
      lat_r <= lat_r + LAT_W'(1); // R7
    end
  end

  // shared release timer
  assign dly.clear = lockout; // R9 R11
  assign dly.reset_cond = reset_cond; // R14
  assign dly.fault_start = enter_fault; // R16
  assign dly.cycle_len = ramp_cyc;

  // cause flags stand until the next fault starts
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      early_r <= 1'b0;
      late_r <= 1'b0;
    end else if (enter_fault) begin
      early_r <= too_early;
      late_r <= too_late;
    end
  end

  // pins sit one flop behind the timer
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      fault_oe_r <= 1'b0;
      rst_oe_r <= 1'b1;
      reg_en_r <= 1'b0;
      ss_clr_r <= 1'b1;
      wd_act_r <= 1'b0;
    end else begin
      fault_oe_r <= dly.fault_busy; // R8
      rst_oe_r <= dly.reset_busy & supok_s; // R10
      reg_en_r <= ~lockout; // R9 R11 R18
      ss_clr_r <= lockout;
      wd_act_r <= in_watch;
    end
  end

  // open-drain pins only ever pull low
  assign WINDOW_FAULT_OUT_N_O = 1'b0;
  assign WINDOW_FAULT_OUT_N_OE = fault_oe_r;
  assign RESET_OUT_N_O = 1'b0;
  assign RESET_OUT_N_OE = rst_oe_r;
  assign REGULATOR_ENABLE = reg_en_r;
  assign SOFTSTART_CLEAR = ss_clr_r;
  assign WATCHDOG_ACTIVE = wd_act_r;
  assign FAULT_EARLY = early_r;
  assign FAULT_LATE = late_r;

endmodule : window_watchdog_reset_supervisor

// ===== verification/wdt_props.sv
`timescale 1ns/1ns
module wdt_props #(
  parameter int SET_W = 4,
  parameter int UPPER_MIN_CYC = 640,
  parameter int UV_CYC = 20
) (
  // inputs
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic KICK_INPUT,
  input wire logic UNDERVOLTAGE_SENSE_IN,
  input wire logic SUPPLY_LOW,
  input wire logic OVERTEMP,
  input wire logic RESET_SUPPLY_OK,
  input wire logic [SET_W-1:0] WINDOW_SETTING,
  input wire logic [SET_W-1:0] DELAY_SETTING,
  // outputs
  input wire logic WINDOW_FAULT_OUT_N_OE,
  input wire logic RESET_OUT_N_OE,
  input wire logic REGULATOR_ENABLE,
  input wire logic SOFTSTART_CLEAR,
  input wire logic WATCHDOG_ACTIVE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  int flt_r;
  int act_r;
  int uv_r;
  int flen;
  int upper;
  assign flen = wdt_pkg::RELEASE_CYCLES * wdt_pkg::MIN_RAMP_CYC
    * (int'(DELAY_SETTING) + 1);
  assign upper = UPPER_MIN_CYC * (int'(WINDOW_SETTING) + 1);
  // kick counted at the pin, two cycles ahead of the design's sync
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      flt_r <= 0;
      act_r <= 0;
      uv_r <= 0;
    end else begin
      flt_r <= WINDOW_FAULT_OUT_N_OE ? flt_r + 1 : 0;
      act_r <= (WATCHDOG_ACTIVE && !$fell(KICK_INPUT)) ? act_r + 1 : 0;
      uv_r <= UNDERVOLTAGE_SENSE_IN ? 0 : uv_r + 1;
    end
  end
  a_supply_low_reset: assert property (
    (SUPPLY_LOW && RESET_SUPPLY_OK)[*5]
    |-> RESET_OUT_N_OE && !REGULATOR_ENABLE && !WATCHDOG_ACTIVE)
    else $error("supply-low state wrong");
  a_hot_reset: assert property (
    (OVERTEMP && RESET_SUPPLY_OK)[*5] |-> RESET_OUT_N_OE && SOFTSTART_CLEAR)
    else $error("overheat state wrong");
  a_sense_reset: assert property (
    RESET_SUPPLY_OK[*5] ##0 (uv_r > UV_CYC + 4) |-> RESET_OUT_N_OE)
    else $error("sense reset missing");
  a_sense_glitch_free: assert property (
    (!RESET_OUT_N_OE && $fell(UNDERVOLTAGE_SENSE_IN))
    ##0 (!SUPPLY_LOW && !OVERTEMP)[*8] |-> !RESET_OUT_N_OE)
    else $error("sense glitch reset");
  a_reg_not_held: assert property (
    (!SUPPLY_LOW && !OVERTEMP)[*5] |-> REGULATOR_ENABLE)
    else $error("regulator held off");
  a_fault_hold: assert property (
    $rose(WINDOW_FAULT_OUT_N_OE) |=> WINDOW_FAULT_OUT_N_OE[*8])
    else $error("fault pulse cut");
  a_fault_len: assert property (
    $fell(WINDOW_FAULT_OUT_N_OE) |-> flt_r >= flen - 2 && flt_r <= flen + 2)
    else $error("fault length wrong");
  a_late_bound: assert property (act_r <= upper + 8)
    else $error("late kick not caught");
  c_fault: cover property ($fell(WINDOW_FAULT_OUT_N_OE));
  c_release: cover property ($fell(RESET_OUT_N_OE));
  c_watch: cover property ($rose(WATCHDOG_ACTIVE));
endmodule : wdt_props

bind window_watchdog_reset_supervisor wdt_props #(
  .SET_W(SET_W),
  .UPPER_MIN_CYC(UPPER_MIN_CYC),
  .UV_CYC(UV_CYC)
) u_wdt_props (.*);

// ===== verification/kick_host.sv
`timescale 1ns/1ns
module kick_host (
  // clock
  input wire logic clk,
  // falling-edge spacing in cycles, 0 holds the pin high
  input wire logic [15:0] period,
  // kick pin
  output logic kick
);
  int cnt_r;
  initial kick = 1'b1;
  always @(posedge clk) begin
    cnt_r <= (period == 0 || cnt_r >= period - 1) ? 0 : cnt_r + 1;
    kick <= (period == 0 || cnt_r < period / 2);
  end
endmodule : kick_host

// ===== verification/window_watchdog_reset_supervisor_bench.sv
`timescale 1ns/1ns
module window_watchdog_reset_supervisor_bench;
  localparam int UP = 640;
  localparam int FLEN = 10000;
  logic CLK, RESETN, KICK_INPUT, SUPERVISOR_ENABLE, UNDERVOLTAGE_SENSE_IN;
  logic SUPPLY_LOW, OVERTEMP, RESET_SUPPLY_OK, FAULT_EARLY, FAULT_LATE;
  logic WINDOW_FAULT_OUT_N_O, WINDOW_FAULT_OUT_N_OE, RESET_OUT_N_O;
  logic RESET_OUT_N_OE, REGULATOR_ENABLE, SOFTSTART_CLEAR, WATCHDOG_ACTIVE;
  logic [15:0] period;
  logic [3:0] wset, dset;
  int n_fail, n_checks, n;
  // open-drain pins with pull-ups
  wire fault_pin = WINDOW_FAULT_OUT_N_OE ? WINDOW_FAULT_OUT_N_O : 1'b1;
  wire rst_pin = RESET_OUT_N_OE ? RESET_OUT_N_O : 1'b1;
  // short window and sense filter keep the run brief
  window_watchdog_reset_supervisor #(.UPPER_MIN_CYC(UP), .UV_CYC(20))
  u_window_watchdog_reset_supervisor (.CLK(CLK), .RESETN(RESETN),
    .KICK_INPUT(KICK_INPUT), .SUPERVISOR_ENABLE(SUPERVISOR_ENABLE),
    .UNDERVOLTAGE_SENSE_IN(UNDERVOLTAGE_SENSE_IN), .SUPPLY_LOW(SUPPLY_LOW),
    .OVERTEMP(OVERTEMP), .RESET_SUPPLY_OK(RESET_SUPPLY_OK),
    .WINDOW_SETTING(wset), .DELAY_SETTING(dset),
    .WINDOW_FAULT_OUT_N_O(WINDOW_FAULT_OUT_N_O),
    .WINDOW_FAULT_OUT_N_OE(WINDOW_FAULT_OUT_N_OE),
    .RESET_OUT_N_O(RESET_OUT_N_O), .RESET_OUT_N_OE(RESET_OUT_N_OE),
    .REGULATOR_ENABLE(REGULATOR_ENABLE), .SOFTSTART_CLEAR(SOFTSTART_CLEAR),
    .WATCHDOG_ACTIVE(WATCHDOG_ACTIVE), .FAULT_EARLY(FAULT_EARLY),
    .FAULT_LATE(FAULT_LATE));
  kick_host u_kick_host (.clk(CLK), .period(period), .kick(KICK_INPUT));
  task automatic cyc(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask : cyc
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic rng(string what, int lo, int hi, int got);
    n_checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : rng
  function automatic logic sel(int w);
    return w == 0 ? fault_pin : (w == 1 ? rst_pin : WATCHDOG_ACTIVE);
  endfunction : sel
  task automatic wait_for(int w, logic v, int lim);
    n = 0;
    while (sel(w) !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_for
  task automatic end_sim;
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  // no kicks at boot: a late fault lands inside the reset delay
  task automatic t_boot;
    cyc(20);
    chk("regulator", 1, REGULATOR_ENABLE);
    chk("reset pin", 0, rst_pin);
    wait_for(1, 1'b1, 16000);
    rng("reset delay", FLEN - 30, FLEN * 3 / 2 + 30, n + 20);
    @(posedge CLK) SUPERVISOR_ENABLE <= 1'b0;
    #1;
    wait_for(0, 1'b1, 12000);
    cyc(30);
    chk("watch off", 0, WATCHDOG_ACTIVE);
    @(posedge CLK) SUPERVISOR_ENABLE <= 1'b1;
    #1;
    wait_for(2, 1'b1, 400);
    rng("enable to watch", 255, 275, n);
  endtask : t_boot
  task automatic t_good;
    @(posedge CLK) period <= 200;
    repeat (15) begin
      cyc(200);
      chk("good kicks", 1, fault_pin);
    end
  endtask : t_good
  // kicks keep coming during the fault and must be ignored
  task automatic t_early_late;
    @(posedge CLK) period <= 30;
    #1;
    wait_for(0, 1'b0, 300);
    chk("early flag", 2'b10, {FAULT_EARLY, FAULT_LATE});
    cyc(5000);
    @(posedge CLK) period <= 0;
    #1;
    wait_for(0, 1'b1, 5200);
    rng("fault length", FLEN - 5, FLEN + 5, n + 5001);
    wait_for(0, 1'b0, 800);
    rng("late detect", UP - 20, UP + 20, n);
    chk("late flag", 2'b01, {FAULT_EARLY, FAULT_LATE});
    wait_for(0, 1'b1, 10100);
    rng("late length", FLEN - 3, FLEN + 3, n);
  endtask : t_early_late
  task automatic t_sense;
    @(posedge CLK) period <= 200;
    cyc(300);
    @(posedge CLK) UNDERVOLTAGE_SENSE_IN <= 1'b0;
    cyc(12);
    @(posedge CLK) UNDERVOLTAGE_SENSE_IN <= 1'b1;
    cyc(30);
    chk("glitch", 1, rst_pin);
    @(posedge CLK) UNDERVOLTAGE_SENSE_IN <= 1'b0;
    cyc(40);
    chk("sense reset", 0, rst_pin);
    @(posedge CLK) RESET_SUPPLY_OK <= 1'b0;
    cyc(8);
    chk("no supply", 1, rst_pin);
    @(posedge CLK) RESET_SUPPLY_OK <= 1'b1;
    cyc(8);
    chk("supply back", 0, rst_pin);
    @(posedge CLK) UNDERVOLTAGE_SENSE_IN <= 1'b1;
    #1;
    wait_for(1, 1'b1, 10100);
    rng("sense release", FLEN - 10, FLEN + 10, n);
    chk("watch kept", 2'b11, {WATCHDOG_ACTIVE, fault_pin});
  endtask : t_sense
  task automatic t_lock;
    for (int i = 0; i < 2; i++) begin
      @(posedge CLK);
      period <= 0;
      SUPPLY_LOW <= (i == 0);
      OVERTEMP <= (i == 1);
      cyc(10);
      chk("lock reset", 0, rst_pin);
      chk("lock reg", 2'b01, {REGULATOR_ENABLE, SOFTSTART_CLEAR});
      chk("lock watch", 0, WATCHDOG_ACTIVE);
      @(posedge CLK);
      SUPPLY_LOW <= 1'b0;
      OVERTEMP <= 1'b0;
      #1;
      wait_for(2, 1'b1, 40);
      rng("lock to watch", 10, 20, n);
      chk("reg on", 2'b10, {REGULATOR_ENABLE, SOFTSTART_CLEAR});
      chk("delay held", 0, rst_pin);
      @(posedge CLK) period <= 200;
      cyc(800);
      chk("no fault", 1, fault_pin);
    end
  endtask : t_lock
  // long window: lower bound is a thirtieth of upper, so 200 is inside
  task automatic t_setting;
    @(posedge CLK);
    period <= 0;
    SUPERVISOR_ENABLE <= 1'b0;
    wset <= 4'h4;
    #1;
    wait_for(1, 1'b1, 10100);
    chk("reset released", 1, rst_pin);
    @(posedge CLK);
    SUPERVISOR_ENABLE <= 1'b1;
    dset <= 4'h1;
    #1;
    wait_for(2, 1'b1, 400);
    @(posedge CLK) period <= 200;
    cyc(1600);
    chk("long window", 1, fault_pin);
    @(posedge CLK) period <= 90;
    #1;
    wait_for(0, 1'b0, 400);
    chk("long early", 2'b10, {FAULT_EARLY, FAULT_LATE});
    wait_for(0, 1'b1, 20100);
    rng("delay setting", 2 * FLEN - 3, 2 * FLEN + 3, n);
  endtask : t_setting
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // about 78k cycles expected; allow about a quarter as much again
  initial begin
    #400000;
    n_fail++;
    end_sim;
  end
  initial begin
    n_fail = 0;
    n_checks = 0;
    period = 16'h0000;
    wset = 4'h0;
    dset = 4'h0;
    RESETN = 1'b0;
    SUPERVISOR_ENABLE = 1'b1;
    UNDERVOLTAGE_SENSE_IN = 1'b1;
    SUPPLY_LOW = 1'b0;
    OVERTEMP = 1'b0;
    RESET_SUPPLY_OK = 1'b1;
    repeat (5) @(posedge CLK);
    RESETN <= 1'b1;
    t_boot;
    t_good;
    t_early_late;
    t_sense;
    t_lock;
    t_setting;
    end_sim;
  end
endmodule : window_watchdog_reset_supervisor_bench
